// File: pkg/asf_pkg.sv
// Shared constants and types for the accelerometer sample buffer and wake block
package asf_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int AXES = 3;
  localparam int SMP_W = 12;
  localparam int RAW_W = 16;
  localparam int BUF_DEPTH = 32;
  localparam int CNT_W = 6;
  localparam int PTR_W = 5;
  localparam int STAGE_DEPTH = 4;
  localparam int NUM_IRQ = 7;
  localparam int NUM_WAKE = 4;
  localparam int GAIN_SHIFT = 9;
  localparam int BASE_SHIFT = 2;
  localparam int SAT_HI = 2047;
  localparam int SAT_LO = -2048;
  localparam logic [SMP_W-1:0] SMP_POS_MAX = 12'h7ff;
  localparam logic [SMP_W-1:0] SMP_NEG_MAX = 12'h800;
  localparam logic [7:0] REG_RESET = 8'h00;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_X_HI = 8'h01;
  localparam logic [7:0] ADDR_Z_HI = 8'h05;
  localparam logic [7:0] ADDR_Z_LO = 8'h06;
  localparam logic [7:0] ADDR_BUF_SETUP = 8'h09;
  localparam logic [7:0] ADDR_TRIG_POST = 8'h0a;
  localparam logic [7:0] ADDR_SYSMODE = 8'h0b;
  localparam logic [7:0] ADDR_RANGE = 8'h0e;
  localparam logic [7:0] ADDR_SLEEP_TIMEOUT = 8'h29;
  localparam logic [7:0] ADDR_PRIMARY_CTL = 8'h2a;
  localparam logic [7:0] ADDR_OVERSAMPLE = 8'h2b;
  localparam logic [7:0] ADDR_WAKE_ROUTE = 8'h2c;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h2d;
  localparam logic [7:0] ADDR_IRQ_ROUTE = 8'h2e;
  localparam logic [7:0] ADDR_UOFF_X = 8'h2f;
  localparam logic [7:0] ADDR_UOFF_Z = 8'h31;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTL_ACTIVE = 0;
  localparam int CTL_FAST_READ = 1;
  localparam int CTL_AUTO_SLEEP = 2;
  localparam int CTL_ODR_LSB = 3;
  localparam int SETUP_MODE_LSB = 6;
  localparam int WAKE_GATE = 7;
  localparam int OVS_SLEEP_ODR_LSB = 6;
  localparam int IRQ_DRDY = 0;
  localparam int IRQ_BUF = 5;
  localparam int IRQ_SLEEP = 6;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    ASF_BUF_OFF = 2'b00,
    ASF_BUF_CIRC = 2'b01,
    ASF_BUF_FILL = 2'b10,
    ASF_BUF_TRIG = 2'b11
  } asf_buf_mode_t;
  typedef enum logic [1:0] {
    ASF_OVS_NORMAL = 2'b00,
    ASF_OVS_LNLP = 2'b01,
    ASF_OVS_HIRES = 2'b10,
    ASF_OVS_LOWPWR = 2'b11
  } asf_ovs_mode_t;
  typedef logic [AXES-1:0][RAW_W-1:0] asf_raw_t;
  typedef logic [AXES-1:0][SMP_W-1:0] asf_smp_t;
  typedef struct packed {logic [7:0] gain; logic [7:0] offset;} asf_trim_t;
  typedef asf_trim_t [AXES-1:0] asf_trim_set_t;
  typedef struct packed {logic transient; logic orient; logic tap; logic motion;} asf_evt_t;
  typedef struct packed {logic wr; logic rd; logic [7:0] addr; logic [7:0] wdata;} asf_reg_req_t;
endpackage

// File: design/asf_fifo.sv
// Small staging FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module asf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
    logic rdy;
  } asf_fifo_st_t;
  localparam asf_fifo_st_t ST_RESET = '{mem: '0, wp: '0, rp: '0, cnt: '0, rdy: 1'b1};
  asf_fifo_st_t st_reg;
  asf_fifo_st_t st_next;
  logic push;
  logic pop;

  assign push = in_valid_in & st_reg.rdy;
  assign pop = out_valid_out & out_ready_in;
  assign in_ready_out = st_reg.rdy;
  assign out_valid_out = (st_reg.cnt != '0);
  assign out_data_out = st_reg.mem[st_reg.rp];

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wp] = in_data_in;
      st_next.wp = (st_reg.wp == AW'(DEPTH - 1)) ? '0 : st_reg.wp + 1'b1;
    end
    if (pop) begin
      st_next.rp = (st_reg.rp == AW'(DEPTH - 1)) ? '0 : st_reg.rp + 1'b1;
    end
    st_next.cnt = st_reg.cnt + CW'(push) - CW'(pop);
    // Registered ready so the source sees a clean flop
    st_next.rdy = (st_next.cnt != CW'(DEPTH));
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule
`default_nettype wire

// File: design/asf_fmt.sv
// Per-axis trim, range scaling, user offset and 12-bit saturation
`timescale 1ns/1ps
`default_nettype none
module asf_fmt
  import asf_pkg::*;
(
  // Raw sample and correction terms
  input wire logic [asf_pkg::RAW_W-1:0] raw_in,
  input wire asf_pkg::asf_trim_t trim_in,
  input wire logic [7:0] user_off_in,
  input wire logic [1:0] range_in,
  // Formatted sample
  output logic [asf_pkg::SMP_W-1:0] smp_out
);
  logic signed [23:0] base;
  logic signed [47:0] prod;
  logic signed [23:0] gained;
  logic signed [23:0] scaled;
  logic signed [23:0] total;
  logic [1:0] rsel;

  always_comb begin
    rsel = (range_in == 2'b11) ? 2'b10 : range_in;
    base = $signed({{8{raw_in[RAW_W-1]}}, raw_in}) + $signed({{16{trim_in.offset[7]}}, trim_in.offset});
    prod = base * $signed({{16{trim_in.gain[7]}}, trim_in.gain});
    gained = base + prod[GAIN_SHIFT +: 24];
    // Wider range means fewer counts per g
    scaled = gained >>> (BASE_SHIFT + int'(rsel));
    total = scaled + $signed({{16{user_off_in[7]}}, user_off_in});
    if (total > SAT_HI) begin
      smp_out = SMP_POS_MAX;
    end else if (total < SAT_LO) begin
      smp_out = SMP_NEG_MAX;
    end else begin
      smp_out = total[SMP_W-1:0];
    end
  end
endmodule
`default_nettype wire

// File: design/asf_top.sv
// Accelerometer sample formatting, 32-entry sample buffer and auto wake/sleep
// Function
// - Trim values load from non-volatile store before any sample is produced.
// - Three volatile 8-bit user offsets, one per axis, adjust output.
// - Each axis sample is 12-bit two's complement in high and low bytes.
// - High byte holds the upper eight bits, a valid 8-bit result.
// - Fast-read bit set delivers only 8-bit results; clear reads 12 bits.
// - One count is 1/1024, 1/512 or 1/256 g per range.
// - Codes saturate between 0x7ff and 0x800.
// - 8-bit result is sixteen times coarser, four low bits dropped.
// - Sample buffer of 32 entries per axis filled without the host.
// - Buffer works at every data rate, with 12-bit or 8-bit readout.
// - Buffer mode fill, circular, trigger or disabled set at offset 0x09.
// - Fill mode keeps first 32, flags overflow, stops until read.
// - Circular mode overwrites oldest so newest 32 samples remain.
// - Trigger mode holds samples to the trigger then a programmed count more.
// - Host is flagged when stored count reaches watermark, 1 to 32.
// - Oversample mode 10 at 0x2B selects high resolution.
// - Oversample mode 11 selects lowest power.
// - Enabled tap, orientation, motion or transient event wakes the device.
// - No enabled event beyond the timeout drops to the sleep rate.
// - Gate bit at 0x2C holds buffer data; buffer events never wake.
// - Continually serviced enabled buffer interrupt keeps device awake.
// - Each of seven interrupt sources routes to either pin.
// - Buffer and wake state reset on standby to active transition.
// - Sampling and buffering run only while active; registers stay open.
`timescale 1ns/1ps
`default_nettype none
module asf_top
  import asf_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Raw samples from the converter
  input wire logic sample_valid_in,
  output logic sample_ready_out,
  input wire asf_pkg::asf_raw_t sample_in,
  // Factory trim
  input wire logic nvm_valid_in,
  input wire asf_pkg::asf_trim_set_t nvm_trim_in,
  // Embedded detector events and buffer trigger
  input wire asf_pkg::asf_evt_t evt_in,
  input wire logic trig_in,
  // Register port from the serial front end
  input wire asf_pkg::asf_reg_req_t reg_req_in,
  output logic [7:0] reg_rdata_out,
  // Pins and analog controls
  output logic irq_pin_a_out,
  output logic irq_pin_b_out,
  output logic sleep_rate_out,
  output logic [2:0] output_data_rate_out,
  output logic [1:0] oversample_mode_out
);
  typedef struct packed {
    logic [BUF_DEPTH-1:0][AXES*SMP_W-1:0] mem;
    logic [AXES*SMP_W-1:0] latest;
    asf_trim_set_t trim;
    logic [AXES-1:0][7:0] uoff;
    logic [7:0] ctl, setup, trig_post, range, oversample, wake;
    logic [7:0] irq_en, irq_route, sleep_to, idle, post_left, rdata;
    logic [PTR_W-1:0] wp;
    logic [PTR_W-1:0] rp;
    logic [CNT_W-1:0] cnt;
    logic trim_ok, active_q, ovf, trig_seen, drdy, awake, sleep_chg, irq_a, irq_b, asleep;
    logic [2:0] output_data_rate;
  } asf_state_t;

  asf_state_t st_reg;
  asf_state_t st_next;
  asf_raw_t stage_data;
  asf_smp_t fmt_smp;
  logic stage_valid, drain_ready, accept, push, pop, ovwr, full, hold;
  logic wm_hit, wake_evt, pop_rd, going_active;
  logic [NUM_IRQ-1:0] irq_src;
  asf_buf_mode_t mode;

  // ----------------------------------------
  // Byte view of a stored sample
  // ----------------------------------------
  function automatic logic [7:0] smp_byte(input logic [SMP_W-1:0] smp, input logic hi);
    smp_byte = hi ? smp[SMP_W-1:4] : {smp[3:0], 4'h0};
  endfunction

  function automatic logic [7:0] data_byte(input asf_state_t s, input logic [7:0] addr);
    logic [2:0] idx;
    logic [SMP_W-1:0] smp;
    idx = 3'(addr - ADDR_X_HI);
    if (asf_buf_mode_t'(s.setup[SETUP_MODE_LSB +: 2]) == ASF_BUF_OFF) begin
      smp = s.latest[idx[2:1]*SMP_W +: SMP_W];
    end else if (s.cnt == '0) begin
      smp = '0;
    end else begin
      smp = s.mem[s.rp][idx[2:1]*SMP_W +: SMP_W];
    end
    data_byte = smp_byte(smp, ~idx[0]);
  endfunction

  // ----------------------------------------
  // Staging FIFO and formatting
  // ----------------------------------------
  asf_fifo #(.WIDTH(AXES * RAW_W), .DEPTH(STAGE_DEPTH)) u_stage (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .in_valid_in(sample_valid_in),
    .in_ready_out(sample_ready_out),
    .in_data_in(sample_in),
    .out_valid_out(stage_valid),
    .out_ready_in(drain_ready),
    .out_data_out(stage_data)
  );

  genvar ax;
  generate
    for (ax = 0; ax < AXES; ax++) begin : g_axis
      asf_fmt u_fmt (
        .raw_in(stage_data[ax]),
        .trim_in(st_reg.trim[ax]),
        .user_off_in(st_reg.uoff[ax]),
        .range_in(st_reg.range[1:0]),
        .smp_out(fmt_smp[ax])
      );
    end
  endgenerate

  // ----------------------------------------
  // Buffer control terms
  // ----------------------------------------
  // Samples wait in staging until trim is loaded and the block is active
  assign drain_ready = st_reg.trim_ok & st_reg.ctl[CTL_ACTIVE];
  assign accept = stage_valid & drain_ready;
  assign mode = asf_buf_mode_t'(st_reg.setup[SETUP_MODE_LSB +: 2]);
  assign full = (st_reg.cnt == CNT_W'(BUF_DEPTH));
  assign hold = st_reg.wake[WAKE_GATE] & ~st_reg.awake;
  // Fast read ends a sample on the last high byte, otherwise on the last low byte
  assign pop_rd = reg_req_in.rd & (st_reg.cnt != '0) & (mode != ASF_BUF_OFF)
    & (reg_req_in.addr == (st_reg.ctl[CTL_FAST_READ] ? ADDR_Z_HI : ADDR_Z_LO));
  assign pop = pop_rd;
  assign wm_hit = (st_reg.setup[5:0] != '0) && (st_reg.cnt >= st_reg.setup[5:0]);
  assign going_active = st_reg.ctl[CTL_ACTIVE] & ~st_reg.active_q;
  assign wake_evt = |(evt_in & st_reg.wake[NUM_WAKE-1:0]) & st_reg.ctl[CTL_ACTIVE];

  always_comb begin
    push = 1'b0;
    ovwr = 1'b0;
    if (accept && !hold) begin
      unique case (mode)
        ASF_BUF_OFF: push = 1'b0;
        ASF_BUF_FILL: push = !full || pop;
        ASF_BUF_CIRC: begin
          push = 1'b1;
          ovwr = full && !pop;
        end
        ASF_BUF_TRIG: begin
          push = st_reg.trig_seen ? ((st_reg.post_left != '0) && (!full || pop)) : 1'b1;
          ovwr = !st_reg.trig_seen && full && !pop;
        end
      endcase
    end
  end

  assign irq_src = {st_reg.sleep_chg, wm_hit | st_reg.ovf, evt_in, st_reg.drdy};

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.active_q = st_reg.ctl[CTL_ACTIVE];
    if (nvm_valid_in && !st_reg.trim_ok) begin
      st_next.trim = nvm_trim_in;
      st_next.trim_ok = 1'b1;
    end
    // Register writes stay open in standby
    if (reg_req_in.wr) begin
      unique case (reg_req_in.addr)
        ADDR_BUF_SETUP: st_next.setup = reg_req_in.wdata;
        ADDR_TRIG_POST: st_next.trig_post = reg_req_in.wdata;
        ADDR_RANGE: st_next.range = reg_req_in.wdata;
        ADDR_SLEEP_TIMEOUT: st_next.sleep_to = reg_req_in.wdata;
        ADDR_PRIMARY_CTL: st_next.ctl = reg_req_in.wdata;
        ADDR_OVERSAMPLE: st_next.oversample = reg_req_in.wdata;
        ADDR_WAKE_ROUTE: st_next.wake = reg_req_in.wdata;
        ADDR_IRQ_ENABLE: st_next.irq_en = reg_req_in.wdata;
        ADDR_IRQ_ROUTE: st_next.irq_route = reg_req_in.wdata;
        default: begin
          if (reg_req_in.addr >= ADDR_UOFF_X && reg_req_in.addr <= ADDR_UOFF_Z) begin
            st_next.uoff[2'(reg_req_in.addr - ADDR_UOFF_X)] = reg_req_in.wdata;
          end
        end
      endcase
    end
    // Clears first so a same-cycle set wins
    if (reg_req_in.rd && reg_req_in.addr == ADDR_SYSMODE) begin
      st_next.sleep_chg = 1'b0;
    end
    if (pop_rd) begin
      st_next.ovf = 1'b0;
      st_next.drdy = 1'b0;
    end
    if (trig_in && mode == ASF_BUF_TRIG && !st_reg.trig_seen && st_reg.ctl[CTL_ACTIVE]) begin
      st_next.trig_seen = 1'b1;
      st_next.post_left = st_reg.trig_post;
    end
    if (accept) begin
      st_next.latest = fmt_smp;
      st_next.drdy = 1'b1;
      if (mode == ASF_BUF_FILL && full && !pop && !hold) begin
        st_next.ovf = 1'b1;
      end
      if (mode == ASF_BUF_TRIG && st_reg.trig_seen && push) begin
        st_next.post_left = st_reg.post_left - 8'h01;
      end
    end
    if (push) begin
      st_next.mem[st_reg.wp] = fmt_smp;
      st_next.wp = st_reg.wp + 1'b1;
    end
    if (pop || ovwr) begin
      st_next.rp = st_reg.rp + 1'b1;
    end
    st_next.cnt = st_reg.cnt + CNT_W'(push) - CNT_W'(pop) - CNT_W'(ovwr);
    // Auto wake/sleep, counted in accepted samples
    if (wake_evt || (pop_rd && st_reg.irq_en[IRQ_BUF] && st_reg.awake)) begin
      st_next.idle = '0;
      if (!st_reg.awake) begin
        st_next.awake = 1'b1;
        st_next.sleep_chg = 1'b1;
      end
    end else if (accept && st_reg.awake && st_reg.ctl[CTL_AUTO_SLEEP]) begin
      if (st_reg.idle > st_reg.sleep_to) begin
        st_next.awake = 1'b0;
        st_next.sleep_chg = 1'b1;
        st_next.idle = '0;
      end else begin
        st_next.idle = st_reg.idle + 8'h01;
      end
    end
    if (going_active) begin
      st_next.wp = '0;
      st_next.rp = '0;
      st_next.cnt = '0;
      st_next.ovf = 1'b0;
      st_next.trig_seen = 1'b0;
      st_next.post_left = '0;
      st_next.drdy = 1'b0;
      st_next.idle = '0;
      st_next.awake = 1'b1;
      st_next.latest = '0;
    end
    st_next.irq_a = |(irq_src & st_reg.irq_en[NUM_IRQ-1:0] & st_reg.irq_route[NUM_IRQ-1:0]);
    st_next.irq_b = |(irq_src & st_reg.irq_en[NUM_IRQ-1:0] & ~st_reg.irq_route[NUM_IRQ-1:0]);
    // Rate pins held in flops, in step with the awake state
    st_next.asleep = ~st_next.awake;
    st_next.output_data_rate = st_next.awake ? st_next.ctl[CTL_ODR_LSB +: 3]
      : {1'b1, st_next.oversample[OVS_SLEEP_ODR_LSB +: 2]};
    // Read data, one cycle after the strobe
    if (reg_req_in.rd) begin
      unique case (reg_req_in.addr)
        ADDR_STATUS: st_next.rdata = {st_reg.ovf, wm_hit, st_reg.cnt};
        ADDR_BUF_SETUP: st_next.rdata = st_reg.setup;
        ADDR_TRIG_POST: st_next.rdata = st_reg.trig_post;
        ADDR_SYSMODE: st_next.rdata = {5'h00, st_reg.sleep_chg, st_reg.trig_seen, st_reg.awake};
        ADDR_RANGE: st_next.rdata = st_reg.range;
        ADDR_SLEEP_TIMEOUT: st_next.rdata = st_reg.sleep_to;
        ADDR_PRIMARY_CTL: st_next.rdata = st_reg.ctl;
        ADDR_OVERSAMPLE: st_next.rdata = st_reg.oversample;
        ADDR_WAKE_ROUTE: st_next.rdata = st_reg.wake;
        ADDR_IRQ_ENABLE: st_next.rdata = st_reg.irq_en;
        ADDR_IRQ_ROUTE: st_next.rdata = st_reg.irq_route;
        default: begin
          if (reg_req_in.addr >= ADDR_X_HI && reg_req_in.addr <= ADDR_Z_LO) begin
            st_next.rdata = data_byte(st_reg, reg_req_in.addr);
          end else if (reg_req_in.addr >= ADDR_UOFF_X && reg_req_in.addr <= ADDR_UOFF_Z) begin
            st_next.rdata = st_reg.uoff[2'(reg_req_in.addr - ADDR_UOFF_X)];
          end else begin
            st_next.rdata = REG_RESET;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rdata_out = st_reg.rdata;
  assign irq_pin_a_out = st_reg.irq_a;
  assign irq_pin_b_out = st_reg.irq_b;
  assign sleep_rate_out = st_reg.asleep;
  assign output_data_rate_out = st_reg.output_data_rate;
  // Resolution or power is traded in the converter; the data path is unchanged
  assign oversample_mode_out = st_reg.oversample[1:0];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  property p_no_sample_before_trim;
    !st_reg.trim_ok |-> !accept;
  endproperty
  a_no_sample_before_trim: assert property (p_no_sample_before_trim)
    else $error("sample accepted before trim load");
  property p_fill_overflow;
    (mode == ASF_BUF_FILL && full && accept && !pop && !hold && !going_active)
      |=> (st_reg.ovf && st_reg.cnt == CNT_W'(BUF_DEPTH) && $stable(st_reg.wp));
  endproperty
  a_fill_overflow: assert property (p_fill_overflow)
    else $error("fill mode did not flag overflow or stored past full");
  property p_circ_overwrite;
    (mode == ASF_BUF_CIRC && full && accept && !pop && !hold && !going_active)
      |=> (st_reg.cnt == CNT_W'(BUF_DEPTH) && st_reg.rp == $past(st_reg.rp) + 1'b1);
  endproperty
  a_circ_overwrite: assert property (p_circ_overwrite)
    else $error("circular mode did not drop the oldest sample");
  property p_pop_count;
    (pop && !push && !going_active) |=> st_reg.cnt == $past(st_reg.cnt) - 1'b1;
  endproperty
  a_pop_count: assert property (p_pop_count)
    else $error("read did not remove a sample");
  property p_watermark;
    (st_reg.setup[5:0] != '0 && st_reg.cnt >= st_reg.setup[5:0] && reg_req_in.rd
      && reg_req_in.addr == ADDR_STATUS) |=> reg_rdata_out[6];
  endproperty
  a_watermark: assert property (p_watermark)
    else $error("watermark not reported");

  property p_wake_on_event;
    wake_evt |=> !sleep_rate_out ##1 (st_reg.irq_en[IRQ_SLEEP] && st_reg.irq_route[IRQ_SLEEP]
      && $past(st_reg.sleep_chg) ? irq_pin_a_out : 1'b1);
  endproperty
  a_wake_on_event: assert property (p_wake_on_event)
    else $error("enabled event did not wake");

  property p_route_a;
    (st_reg.drdy && st_reg.irq_en[IRQ_DRDY] && st_reg.irq_route[IRQ_DRDY]) |=> irq_pin_a_out;
  endproperty
  a_route_a: assert property (p_route_a)
    else $error("routed interrupt missing on pin a");

  property p_low_nibble;
    (reg_req_in.rd && reg_req_in.addr >= ADDR_X_HI && reg_req_in.addr <= ADDR_Z_LO
      && reg_req_in.addr[0] == 1'b0) |=> reg_rdata_out[3:0] == 4'h0;
  endproperty
  a_low_nibble: assert property (p_low_nibble)
    else $error("low byte lower nibble not zero");

  property p_activate_clears;
    going_active |=> (st_reg.cnt == '0 && !st_reg.ovf && !sleep_rate_out);
  endproperty
  a_activate_clears: assert property (p_activate_clears)
    else $error("standby to active did not reset buffer state");
endmodule
`default_nettype wire

// File: bench/asf_host.sv
// Host model driving the register port of the sample block
`timescale 1ns/1ps
`default_nettype none
module asf_host
  import asf_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Register port
  output var asf_pkg::asf_reg_req_t req_out,
  input wire logic [7:0] rdata_in
);
  initial req_out = '0;
  // One access per call; strobe held for exactly one taking edge
  // Buffer mode and fast-read choices come from the caller
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge clk_in);
    #1 req_out = {w, ~w, a, d};
    @(posedge clk_in);
    // Released strobes drop to zero; address and data lines show the inverse, never the last value
    #1 req_out = {2'b00, ~a, ~d};
    q = rdata_in;
  endtask
endmodule
`default_nettype wire

// File: bench/asf_top_tb.sv
// Self-checking bench for the sample buffer and wake block
`timescale 1ns/1ps
`default_nettype none
module asf_top_tb;
  import asf_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} asf_row_t;
  logic clk_in, resetn_in, sample_valid_in, nvm_valid_in, trig_in, sample_ready_out;
  logic irq_a, irq_b, slp;
  logic [2:0] output_data_rate;
  logic [7:0] rdata, q;
  logic [1:0] ovs;
  asf_raw_t sample_in;
  asf_trim_set_t nvm_trim_in;
  asf_evt_t evt_in;
  asf_reg_req_t req;
  int mismatches, compares, cycles;
  asf_row_t rows [7] = '{'{8'h09, 8'h5a, 8'h5a}, '{8'h2b, 8'hc2, 8'hc2},
    '{8'h2c, 8'h85, 8'h85}, '{8'h2f, 8'h7f, 8'h7f}, '{8'h31, 8'h80, 8'h80},
    '{8'h7f, 8'hff, 8'h00}, '{8'h01, 8'h55, 8'h00}};
  logic [7:0] smp [6] = '{8'h49, 8'h00, 8'h7f, 8'hf0, 8'h80, 8'h00};
  asf_top asf_top_i (.clk_in(clk_in), .resetn_in(resetn_in), .sample_valid_in(sample_valid_in),
    .sample_ready_out(sample_ready_out), .sample_in(sample_in), .nvm_valid_in(nvm_valid_in),
    .nvm_trim_in(nvm_trim_in), .evt_in(evt_in), .trig_in(trig_in), .reg_req_in(req),
    .reg_rdata_out(rdata), .irq_pin_a_out(irq_a), .irq_pin_b_out(irq_b), .sleep_rate_out(slp),
    .output_data_rate_out(output_data_rate), .oversample_mode_out(ovs));
  asf_host asf_host_i (.clk_in(clk_in), .req_out(req), .rdata_in(rdata));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    asf_host_i.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    asf_host_i.xfer(1'b0, a, 8'h00, q);
    check(q, e);
  endtask
  task automatic push(input asf_raw_t s);
    int n;
    n = 0;
    @(posedge clk_in);
    #1 sample_in = s;
    sample_valid_in = 1'b1;
    // Ready is a flop, so its value just after an edge holds to the next
    while (!sample_ready_out && n < 50) begin
      n++;
      @(posedge clk_in);
      #1;
    end
    if (n == 50) mismatches++;
    @(posedge clk_in);
    #1 sample_valid_in = 1'b0;
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    resetn_in = 1'b0;
    sample_valid_in = 1'b0;
    nvm_valid_in = 1'b0;
    trig_in = 1'b0;
    evt_in = '0;
    sample_in = '0;
    nvm_trim_in = '0;
    repeat (6) @(posedge clk_in);
    #1 resetn_in = 1'b1;
    nvm_valid_in = 1'b1;
    check({7'h00, sample_ready_out}, 8'h01);
    check({2'h0, irq_a, irq_b, slp, output_data_rate}, 8'h00);
    @(posedge clk_in);
    #1 nvm_valid_in = 1'b0;
    rd(8'h00, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    for (int m = 2; m < 4; m++) begin
      wr(8'h2b, 8'(m));
      check({6'h00, ovs}, 8'(m));
    end
    // Fill mode, watermark 32, buffer source routed to pin a
    wr(8'h2f, 8'h04);
    wr(8'h31, 8'h00);
    wr(8'h0e, 8'h00);
    wr(8'h2d, 8'h20);
    wr(8'h2e, 8'h20);
    wr(8'h09, 8'ha0);
    wr(8'h2a, 8'h01);
    push({16'h8000, 16'h7fff, 16'h1230});
    repeat (8) @(posedge clk_in);
    foreach (smp[i]) rd(8'(i + 1), smp[i]);
    for (int i = 0; i < 33; i++) push('0);
    repeat (8) @(posedge clk_in);
    rd(8'h00, 8'he0);
    check({6'h00, irq_a, irq_b}, 8'h02);
    rd(8'h06, 8'h00);
    rd(8'h00, 8'h1f);
    wr(8'h2a, 8'h03);
    rd(8'h05, 8'h00);
    rd(8'h00, 8'h1e);
    wr(8'h2a, 8'h00);
    wr(8'h2a, 8'h01);
    rd(8'h00, 8'h00);
    // Auto sleep on the fourth idle sample, sleep change routed to pin b
    wr(8'h29, 8'h02);
    wr(8'h2d, 8'h40);
    wr(8'h2a, 8'h2d);
    check({2'h0, irq_a, irq_b, slp, output_data_rate}, 8'h05);
    repeat (4) push('0);
    rd(8'h0b, 8'h04);
    check({2'h0, irq_a, irq_b, slp, output_data_rate}, 8'h1c);
    push('0);
    rd(8'h00, 8'h04);
    @(posedge clk_in);
    #1 evt_in = 4'h1;
    @(posedge clk_in);
    #1 evt_in = '0;
    rd(8'h0b, 8'h05);
    check({2'h0, irq_a, irq_b, slp, output_data_rate}, 8'h15);
    // Circular keeps the newest 32 of 34; z high byte numbers each sample
    wr(8'h2a, 8'h00);
    wr(8'h09, 8'h40);
    wr(8'h2a, 8'h01);
    for (int i = 0; i < 34; i++) push({16'(i << 6), 32'h0});
    rd(8'h05, 8'h02);
    rd(8'h00, 8'h20);
    // Trigger after four samples, two more kept, data ready on pin a
    wr(8'h2a, 8'h00);
    wr(8'h0a, 8'h02);
    wr(8'h09, 8'hc0);
    wr(8'h2d, 8'h01);
    wr(8'h2e, 8'h01);
    wr(8'h2a, 8'h01);
    for (int i = 0; i < 8; i++) begin
      if (i == 4) begin
        @(posedge clk_in);
        #1 trig_in = 1'b1;
        @(posedge clk_in);
        #1 trig_in = 1'b0;
      end
      push({16'(i << 6), 32'h0});
    end
    rd(8'h00, 8'h06);
    rd(8'h0b, 8'h03);
    check({6'h00, irq_a, irq_b}, 8'h02);
    test_done();
  end
endmodule
`default_nettype wire
